// ### hdl/cem_clock_event_monitor.sv
// clock event monitor: sticky flags, mask, summary, status pin
// Behaviour
// - summary high when any unmasked flag set
// - summary register read-only, bits 7-1 reserved
// - summary routed to status pin when selected
// - realign flag bit 2 set on realignment
// - divider mismatch flag bit 0 set
// - flags sticky, write one clears
// - reset sets all flags, status 0x05
// - status bits 7-3 and 1 read zero
// - mask bit 2 hides realign flag
// - mask bit 0 hides divider flag
`timescale 1ns/1ns
module cem_clock_event_monitor (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [11:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic realignEvent,
    input wire logic dividerAMatch,
    input wire logic dividerBMatch,
    input wire logic [1:0] statusPinSel,
    input wire logic calDone,
    output logic calStatusPin,
    output logic summary
);
    logic [7:0] event_mask_reg;
    logic clock_realign_flag;
    logic divider_mismatch_flag;
    logic statusWrite;
    logic realignClear;
    logic dividerClear;
    logic mismatchSeen;
    logic [7:0] event_status_reg;
    logic realign_flag_mask;
    logic divider_flag_mask;
    logic maskWrite;
    logic [7:0] readValue;

    // divider agreement comes from logic on the same clock
    assign mismatchSeen = dividerAMatch != dividerBMatch;
    assign statusWrite = regWrite && regAddr == cem_pkg::STATUS_ADDR;
    assign realignClear = statusWrite && regWdata[cem_pkg::REALIGN_BIT];
    assign dividerClear = statusWrite && regWdata[cem_pkg::DIVIDER_BIT];
    assign maskWrite = regWrite && regAddr == cem_pkg::MASK_ADDR;

    cem_sticky_flag realignFlagInst (
        .clk(clk),
        .reset_n(reset_n),
        .setEvent(realignEvent),
        .clearPulse(realignClear),
        .flag(clock_realign_flag)
    );

    cem_sticky_flag dividerFlagInst (
        .clk(clk),
        .reset_n(reset_n),
        .setEvent(mismatchSeen),
        .clearPulse(dividerClear),
        .flag(divider_mismatch_flag)
    );

    always_comb begin
        event_status_reg = 8'h00;
        event_status_reg[cem_pkg::REALIGN_BIT] = clock_realign_flag;
        event_status_reg[cem_pkg::DIVIDER_BIT] = divider_mismatch_flag;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            event_mask_reg <= cem_pkg::MASK_RESET;
        end else if (maskWrite) begin
            event_mask_reg <= regWdata;
        end
    end

    assign realign_flag_mask = event_mask_reg[cem_pkg::REALIGN_BIT];
    assign divider_flag_mask = event_mask_reg[cem_pkg::DIVIDER_BIT];

    // summary is combinational; the pin is registered and, when statusPinSel selects summary, follows it one clock later
    assign summary = (clock_realign_flag && !realign_flag_mask)
        || (divider_mismatch_flag && !divider_flag_mask);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            calStatusPin <= 1'b0;
        end else if (statusPinSel == cem_pkg::PIN_SEL_SUMMARY) begin
            calStatusPin <= summary;
        end else begin
            calStatusPin <= calDone;
        end
    end

    // writes to the summary address are ignored
    always_comb begin
        readValue = 8'h00;
        case (regAddr)
            cem_pkg::SUMMARY_ADDR: begin
                readValue[cem_pkg::SUMMARY_BIT] = summary;
            end
            cem_pkg::STATUS_ADDR: readValue = event_status_reg;
            cem_pkg::MASK_ADDR: readValue = event_mask_reg;
            default: readValue = 8'h00;
        endcase
    end

    // read data holds until the next read so software may poll slowly
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            regRdata <= readValue;
        end
    end

    a_summary_tracks: assert property (
        @(posedge clk) disable iff (!reset_n)
        summary == |(event_status_reg & ~event_mask_reg & cem_pkg::FLAG_BITS)
    ) else $error("summary wrong");

    a_summary_ro: assert property (
        @(posedge clk) disable iff (!reset_n)
        regRead && regAddr == cem_pkg::SUMMARY_ADDR |=> regRdata[7:1] == 7'h00
    ) else $error("summary upper bits");

    a_pin_route: assert property (
        @(posedge clk) disable iff (!reset_n)
        statusPinSel == cem_pkg::PIN_SEL_SUMMARY |=> calStatusPin == $past(summary)
    ) else $error("pin not summary");

    a_realign_set: assert property (
        @(posedge clk) disable iff (!reset_n)
        realignEvent |=> clock_realign_flag
    ) else $error("realign flag not set");

    a_divider_set: assert property (
        @(posedge clk) disable iff (!reset_n)
        dividerAMatch != dividerBMatch |=> divider_mismatch_flag
    ) else $error("divider flag not set");

    a_flag_clear: assert property (
        @(posedge clk) disable iff (!reset_n)
        realignClear && !realignEvent |=> !clock_realign_flag
    ) else $error("realign not cleared");

    a_flag_hold: assert property (
        @(posedge clk) disable iff (!reset_n)
        clock_realign_flag && !realignClear |=> clock_realign_flag
    ) else $error("realign flag dropped");

    a_reset_value: assert property (
        @(posedge clk)
        !reset_n |=> event_status_reg == cem_pkg::STATUS_RESET &&
        event_mask_reg == cem_pkg::MASK_RESET
    ) else $error("reset values wrong");

    a_reserved_zero: assert property (
        @(posedge clk)
        (event_status_reg & ~cem_pkg::FLAG_BITS) == 8'h00
    ) else $error("reserved status bits set");

    a_mask_hides: assert property (
        @(posedge clk) disable iff (!reset_n)
        realign_flag_mask && divider_flag_mask |-> !summary
    ) else $error("masked flag leaked");

    a_set_wins: assert property (
        @(posedge clk) disable iff (!reset_n)
        dividerClear && mismatchSeen |=> divider_mismatch_flag
    ) else $error("event lost on clear");

    a_realign_wins: assert property (
        @(posedge clk) disable iff (!reset_n)
        realignClear && realignEvent |=> clock_realign_flag
    ) else $error("realign event lost on clear");

    a_divider_clear: assert property (
        @(posedge clk) disable iff (!reset_n)
        dividerClear && !mismatchSeen |=> !divider_mismatch_flag
    ) else $error("divider not cleared");

    a_divider_hold: assert property (
        @(posedge clk) disable iff (!reset_n)
        divider_mismatch_flag && !dividerClear |=> divider_mismatch_flag
    ) else $error("divider flag dropped");

    a_realign_quiet: assert property (
        @(posedge clk) disable iff (!reset_n)
        !clock_realign_flag && !realignEvent |=> !clock_realign_flag
    ) else $error("realign flag set with no event");

    a_divider_quiet: assert property (
        @(posedge clk) disable iff (!reset_n)
        !divider_mismatch_flag && !mismatchSeen |=> !divider_mismatch_flag
    ) else $error("divider flag set with no event");

    a_mask_write: assert property (
        @(posedge clk) disable iff (!reset_n)
        maskWrite |=> event_mask_reg == $past(regWdata)
    ) else $error("mask write lost");

    a_mask_stable: assert property (
        @(posedge clk) disable iff (!reset_n)
        !maskWrite |=> $stable(event_mask_reg)
    ) else $error("mask changed with no write");

    a_summary_read: assert property (
        @(posedge clk) disable iff (!reset_n)
        regRead && regAddr == cem_pkg::SUMMARY_ADDR
        |=> regRdata[cem_pkg::SUMMARY_BIT] == $past(summary)
    ) else $error("summary read wrong");

    a_status_read: assert property (
        @(posedge clk) disable iff (!reset_n)
        regRead && regAddr == cem_pkg::STATUS_ADDR
        |=> regRdata == $past(event_status_reg)
    ) else $error("status read wrong");

    a_summary_write: assert property (
        @(posedge clk) disable iff (!reset_n)
        regWrite && regAddr == cem_pkg::SUMMARY_ADDR && !realignEvent
        && !mismatchSeen |=> $stable(event_status_reg) && $stable(event_mask_reg)
    ) else $error("summary write had effect");

    a_pin_caldone: assert property (
        @(posedge clk) disable iff (!reset_n)
        statusPinSel != cem_pkg::PIN_SEL_SUMMARY |=> calStatusPin == $past(calDone)
    ) else $error("pin not calibration status");

    c_realign: cover property (@(posedge clk) realignEvent && realignClear);
    c_summary: cover property (@(posedge clk) $rose(summary));
    c_pin: cover property (@(posedge clk) $rose(calStatusPin));
    c_divider_wins: cover property (@(posedge clk) dividerClear && mismatchSeen);
    c_pin_caldone: cover property (@(posedge clk)
        calStatusPin && statusPinSel != cem_pkg::PIN_SEL_SUMMARY);
endmodule

// ### hdl/cem_pkg.sv
// constants for the clock event monitor
package cem_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam logic [11:0] SUMMARY_ADDR = 12'h2C0;
    localparam logic [11:0] STATUS_ADDR = 12'h2C1;
    localparam logic [11:0] MASK_ADDR = 12'h2C2;
    localparam logic [7:0] STATUS_RESET = 8'h05;
    localparam logic [7:0] MASK_RESET = 8'h05;
    localparam int REALIGN_BIT = 2;
    localparam int DIVIDER_BIT = 0;
    localparam int SUMMARY_BIT = 0;
    localparam logic [7:0] FLAG_BITS = 8'h05;
    localparam logic [1:0] PIN_SEL_SUMMARY = 2'h1;
endpackage

// ### hdl/cem_sticky_flag.sv
// one sticky event flag, write one to clear, set wins
`timescale 1ns/1ns
module cem_sticky_flag (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic setEvent,
    input wire logic clearPulse,
    output logic flag
);
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flag <= 1'b1;
        end else if (setEvent) begin
            flag <= 1'b1;
        end else if (clearPulse) begin
            flag <= 1'b0;
        end
    end
endmodule

// ### sim/clock_event_monitor_bench.sv
// self-checking bench for the clock event monitor
`timescale 1ns/1ns
module clock_event_monitor_bench;
    logic clk = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic [11:0] regAddr = 12'h000;
    logic [7:0] regWdata = 8'h00;
    logic [7:0] regRdata;
    logic realignEvent = 1'b0, dividerAMatch = 1'b0, dividerBMatch = 1'b0;
    logic [1:0] statusPinSel = 2'h1;
    logic calDone = 1'b0;
    logic calStatusPin, summary;
    int fail_count = 0, n_tests = 0;
    always #5 clk = ~clk;
    cem_clock_event_monitor dut (.clk(clk), .reset_n(reset_n),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWdata(regWdata), .regRdata(regRdata),
        .realignEvent(realignEvent), .dividerAMatch(dividerAMatch),
        .dividerBMatch(dividerBMatch), .statusPinSel(statusPinSel),
        .calDone(calDone), .calStatusPin(calStatusPin), .summary(summary));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        @(posedge clk) #1;
        regWrite = 1'b0;
    endtask
    // data lands on the edge that takes the strobe, and is checked one edge later
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk) #1;
        regRead = 1'b1;
        regAddr = a;
        @(posedge clk) #1;
        regRead = 1'b0;
        @(posedge clk) #1;
        chk(regRdata, e);
    endtask
    task automatic pin(input logic e);
        repeat (2) @(posedge clk);
        #1 chk({7'h00, calStatusPin}, {7'h00, e});
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #20000;
        fail_count++;
        give_verdict();
    end
    initial begin
        repeat (12) @(posedge clk);
        #1 reset_n = 1'b1;
        rd(cem_pkg::STATUS_ADDR, 8'h05);
        rd(cem_pkg::MASK_ADDR, 8'h05);
        rd(cem_pkg::SUMMARY_ADDR, 8'h00);
        // reserved mask bits are stored as written
        wr(cem_pkg::MASK_ADDR, 8'hFA);
        rd(cem_pkg::MASK_ADDR, 8'hFA);
        chk({7'h00, summary}, 8'h01);
        pin(1'b1);
        statusPinSel = 2'h0;
        pin(1'b0);
        calDone = 1'b1;
        pin(1'b1);
        // other codes pass the calibration status, not the summary
        statusPinSel = 2'h3;
        calDone = 1'b0;
        pin(1'b0);
        statusPinSel = 2'h1;
        wr(cem_pkg::SUMMARY_ADDR, 8'hFF);
        rd(cem_pkg::SUMMARY_ADDR, 8'h01);
        wr(cem_pkg::STATUS_ADDR, 8'hFF);
        rd(cem_pkg::STATUS_ADDR, 8'h00);
        chk({7'h00, summary}, 8'h00);
        realignEvent = 1'b1;
        @(posedge clk) #1 realignEvent = 1'b0;
        rd(cem_pkg::STATUS_ADDR, 8'h04);
        chk({7'h00, summary}, 8'h01);
        wr(cem_pkg::STATUS_ADDR, 8'h00);
        rd(cem_pkg::STATUS_ADDR, 8'h04);
        wr(cem_pkg::MASK_ADDR, 8'h04);
        chk({7'h00, summary}, 8'h00);
        wr(cem_pkg::STATUS_ADDR, 8'h04);
        dividerAMatch = 1'b1;
        @(posedge clk) #1 dividerAMatch = 1'b0;
        rd(cem_pkg::STATUS_ADDR, 8'h01);
        chk({7'h00, summary}, 8'h01);
        wr(cem_pkg::MASK_ADDR, 8'h01);
        chk({7'h00, summary}, 8'h00);
        // clear and fresh events in one cycle: both events must survive
        @(posedge clk) #1;
        regWrite = 1'b1;
        regAddr = cem_pkg::STATUS_ADDR;
        regWdata = 8'h05;
        realignEvent = 1'b1;
        dividerBMatch = 1'b1;
        @(posedge clk) #1 regWrite = 1'b0;
        realignEvent = 1'b0;
        dividerBMatch = 1'b0;
        rd(cem_pkg::STATUS_ADDR, 8'h05);
        reset_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 reset_n = 1'b1;
        rd(cem_pkg::STATUS_ADDR, 8'h05);
        rd(cem_pkg::MASK_ADDR, 8'h05);
        give_verdict();
    end
endmodule
